// >>> rtl/chkpnl_top.sv
/*
  Lamp, contact-input and output-contact logic of the checkback panel.
  Assumes the checkback protocol logic on the same clock supplies one-cycle
  event pulses and levels, and that the two contact inputs and the selector
  are asynchronous pins, high while closed or on.
*/
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module chkpnl_top
  import chkpnl_pkg::*;
#(
  parameter logic [31:0] HOLD_CYC      = chkpnl_pkg::HOLD_CYC,
  parameter logic [31:0] MOMENTARY_CYC = chkpnl_pkg::MOMENTARY_CYC,
  parameter logic [31:0] RECOV_PUL_CYC = chkpnl_pkg::RECOV_PUL_CYC,
  parameter logic [31:0] BUCKET_CYC    = chkpnl_pkg::BUCKET_CYC,
  parameter logic [31:0] DEBOUNCE_CYC  = chkpnl_pkg::DEBOUNCE_CYC,
  parameter logic [31:0] PWRUP_CYC     = chkpnl_pkg::PWRUP_CYC,
  parameter logic [31:0] BLINK_CYC     = chkpnl_pkg::BLINK_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic [3:0]  config_selector,
  input  wire logic        external_clear_input,
  input  wire logic        external_test_input,
  input  wire logic        hp_fail_evt,
  input  wire logic        hp_pass_evt,
  input  wire logic        lp_fail_evt,
  input  wire logic        lp_pass_evt,
  input  wire logic        test_pass_evt,
  input  wire logic        test_fail_evt,
  input  wire logic        test_in_progress,
  input  wire logic        recovery_active,
  input  wire logic        recovery_success_evt,
  input  wire logic        recovery_window_evt,
  input  wire logic        spurious_msg_evt,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [31:0]      reg_rdata,
  output logic [9:0]       lamps,
  output logic [4:0]       contact_closed,
  output logic             checkback_req,
  output logic             loopback_req,
  output logic             recovery_clear_req,
  output logic             auto_test_enable
);
  import chkpnl_pkg::*;

  if (HOLD_CYC < 32'h1 || MOMENTARY_CYC < 32'h1 || RECOV_PUL_CYC < 32'h1 ||
      BUCKET_CYC < 32'h1 || DEBOUNCE_CYC < 32'h1 || PWRUP_CYC < 32'h1 ||
      BLINK_CYC < 32'h1) begin : g_bad_count
    $error("chkpnl_top: every cycle count must be at least one");
  end

  function automatic chkpnl_cfg_t decode_cfg(input logic [2:0] sel);
    chkpnl_cfg_t c;
    c = CFG_CUSTOM;
    unique case (sel)
      3'b001:  c = CFG_PRESET1;
      3'b010:  c = CFG_PRESET2;
      3'b011:  c = CFG_PRESET3;
      3'b100:  c = CFG_PRESET4;
      default: c = CFG_CUSTOM;
    endcase
    return c;
  endfunction

  function automatic logic [10:0] bucket_sum(input logic [NOISE_BUCKETS-1:0][7:0] b);
    logic [10:0] s;
    s = 11'h000;
    for (int k = 0; k < NOISE_BUCKETS; k++) begin
      s = s + {3'h0, b[k]};
    end
    return s;
  endfunction

  function automatic logic drive_level(input logic energized, input logic pol);
    return pol ? energized : !energized;
  endfunction

  // Synchronisers: first stage is read only by the second stage.
  logic [5:0]  sync_a;
  logic [5:0]  sync_b;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
    end else begin
      sync_a <= {external_test_input, external_clear_input, config_selector};
      sync_b <= sync_a;
    end
  end

  // Power-up flash window; the selector is captured once at its end.
  logic [31:0] pwr_cnt;
  logic        pwr_done;
  chkpnl_cfg_t cfg;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pwr_cnt  <= 32'h0;
      pwr_done <= 1'b0;
      cfg      <= CFG_CUSTOM;
    end else if (!pwr_done) begin
      if (pwr_cnt >= PWRUP_CYC - 32'h1) begin
        pwr_done <= 1'b1;
        cfg      <= decode_cfg(sync_b[2:0]);
      end else begin
        pwr_cnt <= pwr_cnt + 32'h1;
      end
    end
  end

  logic [31:0] blink_cnt;
  logic        blink;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      blink_cnt <= 32'h0;
      blink     <= 1'b1;
    end else if (blink_cnt >= BLINK_CYC - 32'h1) begin
      blink_cnt <= 32'h0;
      blink     <= !blink;
    end else begin
      blink_cnt <= blink_cnt + 32'h1;
    end
  end

  // Debounce: bit 0 clear input, bit 1 test input.
  logic [1:0]       db_state;
  logic [1:0][31:0] db_cnt;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      db_state <= 2'b00;
      db_cnt   <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (sync_b[4+i] == db_state[i]) begin
          db_cnt[i] <= 32'h0;
        end else if (db_cnt[i] >= DEBOUNCE_CYC - 32'h1) begin
          db_state[i] <= sync_b[4+i];
          db_cnt[i]   <= 32'h0;
        end else begin
          db_cnt[i] <= db_cnt[i] + 32'h1;
        end
      end
    end
  end

  wire logic clr_on = db_state[0];
  wire logic tst_on = db_state[1];

  // Closure decoder.
  chkpnl_sw_t  sw_state;
  chkpnl_sw_t  next_sw_state;
  logic [31:0] hold_cnt;
  logic        alarm_clear;
  logic        toggle_auto;
  logic        next_checkback;
  logic        next_loopback;
  logic        next_recov_clr;
  logic        next_alarm_clr;
  logic        next_toggle;

  wire logic held_long = hold_cnt >= HOLD_CYC - 32'h1;

  always_comb begin
    next_sw_state  = sw_state;
    next_checkback = 1'b0;
    next_loopback  = 1'b0;
    next_recov_clr = 1'b0;
    next_alarm_clr = 1'b0;
    next_toggle    = 1'b0;
    unique case (sw_state)
      SW_IDLE: begin
        if (clr_on && tst_on) begin
          next_sw_state = SW_BOTH;
        end else if (clr_on) begin
          next_sw_state = SW_CLEAR;
        end else if (tst_on) begin
          next_sw_state = SW_TEST;
        end
      end
      SW_CLEAR: begin
        if (tst_on) begin
          next_sw_state = SW_BOTH;
        end else if (!clr_on) begin
          next_alarm_clr = 1'b1;
          next_sw_state  = SW_IDLE;
        end else if (held_long) begin
          next_recov_clr = 1'b1;
          next_sw_state  = SW_WAIT;
        end
      end
      SW_TEST: begin
        if (clr_on) begin
          next_sw_state = SW_BOTH;
        end else if (!tst_on) begin
          next_checkback = 1'b1;
          next_sw_state  = SW_IDLE;
        end else if (held_long) begin
          next_loopback = 1'b1;
          next_sw_state = SW_WAIT;
        end
      end
      SW_BOTH: begin
        if (!clr_on && !tst_on) begin
          next_toggle   = 1'b1;
          next_sw_state = SW_IDLE;
        end
      end
      SW_WAIT: begin
        if (!clr_on && !tst_on) begin
          next_sw_state = SW_IDLE;
        end
      end
      default: next_sw_state = SW_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sw_state           <= SW_IDLE;
      hold_cnt           <= 32'h0;
      checkback_req      <= 1'b0;
      loopback_req       <= 1'b0;
      recovery_clear_req <= 1'b0;
      alarm_clear        <= 1'b0;
      toggle_auto        <= 1'b0;
    end else begin
      sw_state           <= next_sw_state;
      checkback_req      <= next_checkback;
      loopback_req       <= next_loopback;
      recovery_clear_req <= next_recov_clr;
      alarm_clear        <= next_alarm_clr;
      toggle_auto        <= next_toggle;
      if (next_sw_state == SW_CLEAR || next_sw_state == SW_TEST) begin
        if (!held_long) begin
          hold_cnt <= hold_cnt + 32'h1;
        end
      end else begin
        hold_cnt <= 32'h0;
      end
    end
  end

  // Settings registers; preset selections lock them at the values held when the power-up window ends.
  logic        sealed;
  logic [4:0]  polarity;
  logic [8:0]  user_sel;
  logic [10:0] noise_thr;
  wire logic   cfg_wr = reg_write && (cfg == CFG_CUSTOM);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sealed    <= RST_SEALED;
      polarity  <= RST_POLARITY;
      user_sel  <= RST_USER_SEL;
      noise_thr <= RST_NOISE_THR;
    end else if (cfg_wr) begin
      if (reg_addr == REG_CTRL) begin
        sealed <= reg_wdata[CTRL_SEALED];
      end
      if (reg_addr == REG_POLARITY) begin
        polarity <= reg_wdata[4:0];
      end
      if (reg_addr == REG_USER_SEL) begin
        user_sel <= reg_wdata[8:0];
      end
      if (reg_addr == REG_NOISE_THR) begin
        noise_thr <= reg_wdata[10:0];
      end
    end
  end

  // Automatic-test enable: the closure toggle wins over a software write.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      auto_test_enable <= RST_AUTO;
    end else if (toggle_auto) begin
      auto_test_enable <= !auto_test_enable;
    end else if (reg_write && reg_addr == REG_CTRL) begin
      auto_test_enable <= reg_wdata[CTRL_AUTO];
    end
  end

  // Alarm and result state; a new event wins over a clear in the same cycle, except delayed, which a window event sets only while recovery_active is high.
  logic sev_flag;
  logic light_flag;
  logic sev_seal;
  logic light_seal;
  logic test_good;
  logic delayed;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sev_flag   <= 1'b0;
      light_flag <= 1'b0;
      sev_seal   <= 1'b0;
      light_seal <= 1'b0;
      test_good  <= 1'b0;
      delayed    <= 1'b0;
    end else begin
      sev_flag   <= hp_fail_evt || (sev_flag && !alarm_clear && !hp_pass_evt);
      light_flag <= lp_fail_evt || (light_flag && !alarm_clear && !lp_pass_evt);
      sev_seal   <= hp_fail_evt || (sev_seal && !hp_pass_evt);
      light_seal <= lp_fail_evt || (light_seal && !lp_pass_evt);
      test_good  <= test_pass_evt || (test_good && !test_fail_evt);
      delayed    <= (recovery_window_evt && recovery_active) ||
                    (delayed && recovery_active);
    end
  end

  // Momentary timers for the two alarm outputs and the recovery pulse.
  logic [31:0] sev_tmr;
  logic [31:0] light_tmr;
  logic [31:0] recov_tmr;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sev_tmr   <= 32'h0;
      light_tmr <= 32'h0;
      recov_tmr <= 32'h0;
    end else begin
      if (hp_fail_evt) begin
        sev_tmr <= MOMENTARY_CYC;
      end else if (sev_tmr != 32'h0) begin
        sev_tmr <= sev_tmr - 32'h1;
      end
      if (lp_fail_evt) begin
        light_tmr <= MOMENTARY_CYC;
      end else if (light_tmr != 32'h0) begin
        light_tmr <= light_tmr - 32'h1;
      end
      if (recovery_success_evt) begin
        recov_tmr <= RECOV_PUL_CYC;
      end else if (recov_tmr != 32'h0) begin
        recov_tmr <= recov_tmr - 32'h1;
      end
    end
  end

  // Rolling noise window made of equal buckets.
  logic [NOISE_BUCKETS-1:0][7:0] bucket;
  logic [2:0]                    bucket_idx;
  logic [31:0]                   bucket_tmr;
  wire logic [10:0]              noise_cnt = bucket_sum(bucket);
  wire logic noise_high = (noise_thr != 11'h000) && (noise_cnt >= noise_thr);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      bucket     <= '0;
      bucket_idx <= 3'h0;
      bucket_tmr <= 32'h0;
    end else if (bucket_tmr >= BUCKET_CYC - 32'h1) begin
      bucket_tmr                       <= 32'h0;
      bucket_idx                       <= bucket_idx + 3'h1;
      bucket[3'(bucket_idx + 3'h1)]    <= {7'h00, spurious_msg_evt};
    end else begin
      bucket_tmr <= bucket_tmr + 32'h1;
      if (spurious_msg_evt && bucket[bucket_idx] != 8'hFF) begin
        bucket[bucket_idx] <= bucket[bucket_idx] + 8'h01;
      end
    end
  end

  // Conditions and contacts.
  logic [4:0] cond;
  logic [4:0] energized;
  logic [2:0] sel;
  always_comb begin
    cond = {!auto_test_enable, recov_tmr != 32'h0, test_good,
            test_in_progress, delayed};
    energized[OUT_SEVERE] = sealed ? sev_seal : (sev_tmr != 32'h0);
    energized[OUT_LIGHT]  = sealed ? light_seal : (light_tmr != 32'h0);
    for (int u = 0; u < 3; u++) begin
      sel = user_sel[u*3 +: 3];
      energized[OUT_USER0+u] = (sel <= COND_DISABLED) ? cond[sel] : 1'b0;
    end
  end

  logic [9:0] next_lamps;
  always_comb begin
    next_lamps              = 10'h000;
    next_lamps[cfg]         = 1'b1;
    next_lamps[LAMP_SEVERE]   = sev_flag;
    next_lamps[LAMP_LIGHT]    = light_flag;
    next_lamps[LAMP_RECOVERY] = recovery_active;
    next_lamps[LAMP_NOISE]    = noise_high && blink;
    next_lamps[LAMP_GOOD]     = test_good;
    if (!auto_test_enable) begin
      for (int j = 0; j < LAMP_GOOD; j++) begin
        if (j != int'(cfg)) begin
          next_lamps[j] = blink;
        end
      end
    end
    if (!pwr_done) begin
      next_lamps = {10{blink}};
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      lamps          <= 10'h000;
      contact_closed <= 5'h00;
    end else begin
      lamps <= next_lamps;
      for (int n = 0; n < 5; n++) begin
        contact_closed[n] <= drive_level(energized[n], polarity[n]);
      end
    end
  end

  // Register read port: data stand for one cycle after the read strobe.
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0;
    unique case (reg_addr)
      REG_CTRL:      rd_val = {30'h0, auto_test_enable, sealed};
      REG_POLARITY:  rd_val = {27'h0, polarity};
      REG_USER_SEL:  rd_val = {23'h0, user_sel};
      REG_NOISE_THR: rd_val = {21'h0, noise_thr};
      REG_STATUS: begin
        rd_val[ST_LAMP_LSB +: 10]   = lamps;
        rd_val[ST_CONTACT_LSB +: 5] = contact_closed;
        rd_val[ST_CFG_LSB +: 3]     = cfg;
        rd_val[ST_DELAYED]          = delayed;
      end
      REG_NOISE_CNT: rd_val = {21'h0, noise_cnt};
      default:       rd_val = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= reg_read ? rd_val : 32'h0;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/chkpnl_pkg.sv
/*
  Constants for the checkback panel logic: register offsets, field positions,
  reset values, lamp positions, encodings and timing counts.
  Assumes a 40 MHz core clock; every cycle count is derived from that rate.
*/
`default_nettype none
package chkpnl_pkg;

  localparam int unsigned CLK_HZ  = 40_000_000;
  localparam int unsigned CLK_KHZ = CLK_HZ / 1000;

  // Times in milliseconds.
  localparam int unsigned HOLD_MS      = 2000;
  localparam int unsigned MOMENTARY_MS = 5000;
  localparam int unsigned RECOV_PUL_MS = 1000;
  localparam int unsigned NOISE_WIN_MS = 120_000;
  localparam int unsigned DEBOUNCE_MS  = 20;
  localparam int unsigned PWRUP_MS     = 1000;
  localparam int unsigned BLINK_MS     = 250;

  localparam int unsigned NOISE_BUCKETS = 8;

  localparam logic [31:0] HOLD_CYC      = 32'(CLK_KHZ * HOLD_MS);
  localparam logic [31:0] MOMENTARY_CYC = 32'(CLK_KHZ * MOMENTARY_MS);
  localparam logic [31:0] RECOV_PUL_CYC = 32'(CLK_KHZ * RECOV_PUL_MS);
  localparam logic [31:0] BUCKET_CYC    = 32'(CLK_KHZ * (NOISE_WIN_MS / NOISE_BUCKETS));
  localparam logic [31:0] DEBOUNCE_CYC  = 32'(CLK_KHZ * DEBOUNCE_MS);
  localparam logic [31:0] PWRUP_CYC     = 32'(CLK_KHZ * PWRUP_MS);
  localparam logic [31:0] BLINK_CYC     = 32'(CLK_KHZ * BLINK_MS);

  // Register word addresses.
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_POLARITY  = 4'h1;
  localparam logic [3:0] REG_USER_SEL  = 4'h2;
  localparam logic [3:0] REG_NOISE_THR = 4'h3;
  localparam logic [3:0] REG_STATUS    = 4'h4;
  localparam logic [3:0] REG_NOISE_CNT = 4'h5;

  // Control register fields.
  localparam int unsigned CTRL_SEALED = 0;
  localparam int unsigned CTRL_AUTO   = 1;

  // Status register fields.
  localparam int unsigned ST_LAMP_LSB    = 0;
  localparam int unsigned ST_CONTACT_LSB = 10;
  localparam int unsigned ST_CFG_LSB     = 15;
  localparam int unsigned ST_DELAYED     = 18;

  localparam logic        RST_SEALED   = 1'b1;
  localparam logic        RST_AUTO     = 1'b1;
  localparam logic [4:0]  RST_POLARITY = 5'h1F;
  localparam logic [8:0]  RST_USER_SEL = 9'h088;
  localparam logic [10:0] RST_NOISE_THR = 11'h010;

  // Lamp positions; configuration lamps take positions 0 to 4 by code.
  localparam int unsigned LAMP_SEVERE   = 5;
  localparam int unsigned LAMP_LIGHT    = 6;
  localparam int unsigned LAMP_RECOVERY = 7;
  localparam int unsigned LAMP_NOISE    = 8;
  localparam int unsigned LAMP_GOOD     = 9;

  // Contact positions.
  localparam int unsigned OUT_SEVERE = 0;
  localparam int unsigned OUT_LIGHT  = 1;
  localparam int unsigned OUT_USER0  = 2;

  typedef enum logic [2:0] {
    CFG_PRESET1 = 3'b000,
    CFG_PRESET2 = 3'b001,
    CFG_PRESET3 = 3'b010,
    CFG_PRESET4 = 3'b011,
    CFG_CUSTOM  = 3'b100
  } chkpnl_cfg_t;

  typedef enum logic [2:0] {
    COND_DELAYED  = 3'b000,
    COND_IN_TEST  = 3'b001,
    COND_PASSED   = 3'b010,
    COND_RECOV_OK = 3'b011,
    COND_DISABLED = 3'b100
  } chkpnl_cond_t;

  typedef enum logic [2:0] {
    SW_IDLE  = 3'b000,
    SW_CLEAR = 3'b001,
    SW_TEST  = 3'b010,
    SW_BOTH  = 3'b011,
    SW_WAIT  = 3'b100
  } chkpnl_sw_t;

endpackage
`default_nettype wire

// >>> dv/chkpnl_properties.sv
/* Port checker for the checkback panel logic.
   Bound into chkpnl_top; a preset selection keeps the settings held when the power-up window ends. */
`timescale 1ns/1ps
`default_nettype none
module chkpnl_properties
  import chkpnl_pkg::*;
#(
  parameter logic [31:0] PWRUP_CYC = 32'h14
) (
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic       hp_fail_evt,
  input wire logic       lp_fail_evt,
  input wire logic       test_pass_evt,
  input wire logic       test_fail_evt,
  input wire logic       test_in_progress,
  input wire logic [9:0] lamps,
  input wire logic [4:0] contact_closed,
  input wire logic       checkback_req,
  input wire logic       loopback_req,
  input wire logic       recovery_clear_req,
  input wire logic       auto_test_enable
);
  logic [7:0] up_cnt;
  logic       up;
  logic       any_req;
  // Cycles since reset release, saturating well after the power-up flash.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      up_cnt <= 8'h00;
    end else if (up_cnt != 8'hFF) begin
      up_cnt <= up_cnt + 8'h01;
    end
  end
  assign up = 32'(up_cnt) > PWRUP_CYC + 32'h4;
  assign any_req = checkback_req | loopback_req | recovery_clear_req;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_settled;
    (up && auto_test_enable) [*3];
  endsequence
  sequence s_preset;
    s_settled ##0 !lamps[4];
  endsequence
  a_reset_idle: assert property ($fell(srst) |-> lamps == 10'h000 && auto_test_enable)
    else $error("outputs not idle after reset");
  a_flash_all: assert property (up_cnt >= 8'h03 && 32'(up_cnt) + 32'h3 <= PWRUP_CYC
    |-> lamps == 10'h000 || lamps == 10'h3FF) else $error("lamps differ in power-up flash");
  a_cfg_onehot: assert property (s_settled |-> $onehot(lamps[4:0]))
    else $error("not one configuration lamp");
  a_cfg_steady: assert property (s_settled |-> $stable(lamps[4:0]))
    else $error("configuration lamp changed");
  a_severe_lamp: assert property (s_settled ##0 hp_fail_evt |-> ##2 lamps[LAMP_SEVERE])
    else $error("severe lamp not lit");
  a_light_lamp: assert property (s_settled ##0 lp_fail_evt |-> ##2 lamps[LAMP_LIGHT])
    else $error("light lamp not lit");
  a_good_dark: assert property (up && test_fail_evt && !test_pass_evt ##1 !test_pass_evt
    |-> ##1 !lamps[LAMP_GOOD]) else $error("test-good lamp lit after failure");
  a_disabled_flash: assert property ((up && !auto_test_enable) [*3]
    |-> lamps[8:5] == 4'h0 || lamps[8:5] == 4'hF) else $error("status lamps not flashing");
  a_req_pulse: assert property (any_req |=> !any_req)
    else $error("request longer than one cycle");
  a_sev_contact: assert property (s_preset ##0 hp_fail_evt |-> ##2 contact_closed[OUT_SEVERE])
    else $error("severe contact not energized");
  a_in_test_out: assert property (s_preset ##0 $stable(test_in_progress) [*2]
    |-> contact_closed[OUT_USER0 + 1] == test_in_progress) else $error("in-test contact wrong");
endmodule
bind chkpnl_top chkpnl_properties #(.PWRUP_CYC(PWRUP_CYC)) u_chkpnl_properties (
  .core_clk(core_clk), .srst(srst), .hp_fail_evt(hp_fail_evt), .lp_fail_evt(lp_fail_evt),
  .test_pass_evt(test_pass_evt), .test_fail_evt(test_fail_evt),
  .test_in_progress(test_in_progress), .lamps(lamps), .contact_closed(contact_closed),
  .checkback_req(checkback_req), .loopback_req(loopback_req),
  .recovery_clear_req(recovery_clear_req), .auto_test_enable(auto_test_enable));
`default_nettype wire

// >>> dv/chkpnl_switch_model.sv
/* Operator contact model for the clear and test inputs.
   Assumes the bench asks for one closure at a time on core_clk. */
`timescale 1ns/1ps
`default_nettype none
module chkpnl_switch_model (
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic [1:0] which,
  input  wire logic [7:0] len,
  output logic            busy,
  output logic            clear_pin,
  output logic            test_pin
);
  logic [7:0] cnt = 8'h00;
  logic [1:0] held = 2'b00;
  initial busy = 1'b0;
  always @(posedge core_clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      held <= which;
      cnt <= 8'h00;
    end else if (busy) begin
      cnt <= cnt + 8'h01;
      busy <= cnt != len;
    end
  end
  // A contact bounces open for one cycle just after it first closes.
  assign clear_pin = busy && held[0] && cnt != 8'h01;
  assign test_pin = busy && held[1] && cnt != 8'h01;
endmodule
`default_nettype wire

// >>> dv/chkpnl_tb_top.sv
/* Self-checking bench for the checkback panel logic.
   Uses short timing parameters; the switch model makes the closures. */
`timescale 1ns/1ps
`default_nettype none
module chkpnl_tb_top;
  import chkpnl_pkg::*;
  typedef struct {logic [1:0] which; logic [7:0] len; logic [2:0] reqs; logic flip;} chkpnl_row_t;
  logic        core_clk;
  logic        srst;
  logic [3:0]  sel;
  logic [8:0]  evts;
  logic        rec_act;
  logic        in_test;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [31:0] reg_rdata;
  logic [9:0]  lamps;
  logic [4:0]  contact;
  logic [2:0]  req_now;
  logic        auto_en;
  logic        sw_go;
  logic [1:0]  sw_which;
  logic [7:0]  sw_len;
  logic        sw_busy;
  logic        clr_pin;
  logic        tst_pin;
  int          req_cnt [3] = '{0, 0, 0};
  int          n_mismatch = 0;
  int          checks_done = 0;
  localparam logic [31:0] T_HOLD = 32'h32, T_MOM = 32'h1E, T_RPUL = 32'h14, T_BKT = 32'h28;
  localparam logic [31:0] T_DEB = 32'h4, T_PWR = 32'h14, T_BLINK = 32'h5;
  // Event bits: hp fail, hp pass, lp fail, lp pass, test pass, test fail,
  // recovery success, recovery window, spurious message.
  chkpnl_top #(.HOLD_CYC(T_HOLD), .MOMENTARY_CYC(T_MOM), .RECOV_PUL_CYC(T_RPUL),
    .BUCKET_CYC(T_BKT), .DEBOUNCE_CYC(T_DEB), .PWRUP_CYC(T_PWR), .BLINK_CYC(T_BLINK))
  u_chkpnl_top (
    .core_clk(core_clk), .srst(srst), .config_selector(sel),
    .external_clear_input(clr_pin), .external_test_input(tst_pin),
    .hp_fail_evt(evts[0]), .hp_pass_evt(evts[1]), .lp_fail_evt(evts[2]),
    .lp_pass_evt(evts[3]), .test_pass_evt(evts[4]), .test_fail_evt(evts[5]),
    .test_in_progress(in_test), .recovery_active(rec_act), .recovery_success_evt(evts[6]),
    .recovery_window_evt(evts[7]), .spurious_msg_evt(evts[8]), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .lamps(lamps), .contact_closed(contact),
    .checkback_req(req_now[2]), .loopback_req(req_now[1]),
    .recovery_clear_req(req_now[0]), .auto_test_enable(auto_en));
  chkpnl_switch_model u_chkpnl_switch_model (
    .core_clk(core_clk), .go(sw_go), .which(sw_which), .len(sw_len),
    .busy(sw_busy), .clear_pin(clr_pin), .test_pin(tst_pin));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    for (int i = 0; i < 3; i++) req_cnt[i] <= req_cnt[i] + int'(req_now[i]);
  end
  task automatic end_sim();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic pulse(input int i);
    @(posedge core_clk);
    evts[i] <= 1'b1;
    @(posedge core_clk);
    evts[i] <= 1'b0;
    cyc(3);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic press(input logic [1:0] w, input logic [7:0] len);
    int k;
    @(posedge core_clk);
    sw_go <= 1'b1;
    sw_which <= w;
    sw_len <= len;
    @(posedge core_clk);
    sw_go <= 1'b0;
    #1;
    k = 0;
    while (sw_busy && k < 300) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 300) begin
      chk("switch release", 32'h0, 32'h1);
      end_sim();
    end
    cyc(20);
  endtask
  initial begin
    static chkpnl_row_t rows [6] = '{'{2'h2, 8'h14, 3'h4, 1'b0}, '{2'h2, 8'h50, 3'h2, 1'b0},
      '{2'h1, 8'h50, 3'h1, 1'b0}, '{2'h1, 8'h14, 3'h0, 1'b0},
      '{2'h3, 8'h14, 3'h0, 1'b1}, '{2'h3, 8'h50, 3'h0, 1'b1}};
    int c0 [3];
    logic a0;
    logic seen;
    logic [2:0] fl;
    logic [31:0] d;
    {srst, sel, evts, rec_act, in_test, reg_addr, reg_wdata} = {1'b1, 4'h9, 47'h0};
    {reg_write, reg_read, sw_go, sw_which, sw_len} = 13'h0;
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    #1;
    chk("reset lamps and auto", 32'h400, {auto_en, lamps});
    seen = 1'b0;
    for (int i = 0; i < 18; i++) begin
      cyc(1);
      seen |= (lamps == 10'h3FF);
    end
    chk("power-up flash", 32'h1, 32'(seen));
    cyc(10);
    chk("preset lamp", 32'h001, 32'(lamps));
    @(posedge core_clk);
    sel <= 4'h4;
    cyc(30);
    chk("preset lamp kept", 32'h001, 32'(lamps));
    foreach (rows[r]) begin
      c0 = req_cnt;
      a0 = auto_en;
      press(rows[r].which, rows[r].len);
      for (int i = 0; i < 3; i++) chk("requests", 32'(rows[r].reqs[i]), 32'(req_cnt[i] - c0[i]));
      chk("auto enable", 32'(a0 ^ rows[r].flip), 32'(auto_en));
    end
    pulse(0);
    chk("severe lamp, contact", 32'h3, {lamps[LAMP_SEVERE], contact[OUT_SEVERE]});
    press(2'h1, 8'h14);
    chk("severe after clear", 32'h1, {lamps[LAMP_SEVERE], contact[OUT_SEVERE]});
    pulse(1);
    chk("severe after pass", 32'h0, 32'(contact[OUT_SEVERE]));
    pulse(2);
    chk("light lamp, contact", 32'h3, {lamps[LAMP_LIGHT], contact[OUT_LIGHT]});
    pulse(3);
    chk("light after pass", 32'h0, 32'(contact[OUT_LIGHT]));
    pulse(4);
    chk("good lamp, passed", 32'h3, {lamps[LAMP_GOOD], contact[OUT_USER0 + 2]});
    pulse(5);
    chk("good lamp dark", 32'h0, 32'(lamps[LAMP_GOOD]));
    rec_act <= 1'b1;
    pulse(7);
    chk("recovery, delayed", 32'h3, {lamps[LAMP_RECOVERY], contact[OUT_USER0]});
    rec_act <= 1'b0;
    pulse(6);
    chk("recovery ended", 32'h0, {lamps[LAMP_RECOVERY], contact[OUT_USER0]});
    in_test <= 1'b1;
    cyc(3);
    chk("in-test contact", 32'h1, 32'(contact[OUT_USER0 + 1]));
    rd(REG_STATUS, d);
    chk("status cfg, lamps", 32'h001, {d[17:15], d[9:0]});
    wr(REG_POLARITY, 32'h0);
    rd(REG_POLARITY, d);
    chk("locked polarity", 32'h1F, d);
    rd(4'hF, d);
    chk("unmapped read", 32'h0, d);
    in_test <= 1'b0;
    repeat (16) pulse(8);
    seen = 1'b0;
    for (int i = 0; i < 12; i++) begin
      cyc(1);
      seen |= lamps[LAMP_NOISE];
    end
    chk("noise lamp", 32'h1, 32'(seen));
    wr(REG_CTRL, 32'h0);
    cyc(3);
    fl = 3'b001;
    for (int i = 0; i < 12; i++) begin
      cyc(1);
      fl = {fl[2] | lamps[LAMP_SEVERE], fl[1] | !lamps[LAMP_SEVERE], fl[0] & lamps[0]};
    end
    chk("flash while disabled", 32'h7, {auto_en, fl});
    rd(REG_CTRL, d);
    chk("control word", 32'h1, d);
    @(posedge core_clk);
    srst <= 1'b1;
    cyc(2);
    chk("second reset", 32'h400, {auto_en, lamps});
    srst <= 1'b0;
    cyc(1);
    chk("flash restarts", 32'h7FF, {auto_en, lamps});
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    chk("run length", 32'h0, 32'h1);
    end_sim();
  end
endmodule
`default_nettype wire
